/* design/port_pins_pkg.sv */
// Constants and types shared by the narrow memory port pin logic.
package port_pins_pkg;

    // Port input clock source codes, as caught from the strap pins.
    localparam logic [1:0] STRAP_EXT   = 2'h0;
    localparam logic [1:0] STRAP_DIV4  = 2'h1;
    localparam logic [1:0] STRAP_DIV6  = 2'h2;

    // Cycles after reset release before the synchronised straps are caught.
    localparam logic [1:0] STRAP_WAIT  = 2'h2;

    // Phase counter limits for the CPU derived port clocks.
    localparam logic [2:0] DIV4_LAST   = 3'h3;
    localparam logic [2:0] DIV4_HALF   = 3'h2;
    localparam logic [2:0] DIV6_LAST   = 3'h5;
    localparam logic [2:0] DIV6_HALF   = 3'h3;
    localparam logic [2:0] CNT_RESET   = 3'h0;

    // Divider selection for the second output clock.
    localparam logic [1:0] OUTDIV_1    = 2'h0;
    localparam logic [1:0] OUTDIV_2    = 2'h1;
    localparam logic [1:0] OUTDIV_4    = 2'h2;

    // Memory types of the space being accessed.
    localparam logic [1:0] MEM_ASYNC   = 2'h0;
    localparam logic [1:0] MEM_SDRAM   = 2'h1;
    localparam logic [1:0] MEM_SYNC    = 2'h2;

    // Number of chip enable outputs.
    localparam int unsigned N_SPACES   = 4;

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_FLOAT, ST_GRANT} port_state_e;

endpackage : port_pins_pkg

/* design/narrow_mem_port_pins.sv */
// Pin level logic of the 16-bit memory port: clocks, strobes, enables and hold handshake.
`timescale 1ns/100ps

// Functional notes
// [RULE1] Byte enables are decoded from the low address bit and the width of the access.
// [RULE2] Byte enables act as byte write enables and double as the SDRAM data mask.
// [RULE3] The port input clock is chosen at reset from the pin, CPU/4 or CPU/6 by two straps.
// [RULE4] With no other source strapped the external clock pin is used.
// [RULE5] The second output clock runs at the port clock divided by one, two or four.
// [RULE6] The first output clock runs at the port clock frequency undivided.
// [RULE7] One shared pin is async read enable, SDRAM column strobe or sync strobe by memory type.
// [RULE8] For sync memory a select of 0 makes that pin the address strobe, else the read enable.
// [RULE9] A second shared pin is async output enable, SDRAM row strobe or sync output enable.
// [RULE10] A peripheral direct transfer output marks transfers between two outside peripherals.
// [RULE11] A host asks for the bus by hold request, gets hold acknowledge, and we raise bus request.
// [RULE12] At most one chip enable is asserted during any access.
// [RULE13] Acknowledge comes only after the access ends and the pins float, and stays until release.
module narrow_mem_port_pins
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Pins from outside
    input  wire logic       i_port_ext_clock_in,
    input  wire logic [1:0] i_clock_source_straps,
    input  wire logic       i_host_hold_request_n,
    // Static control
    input  wire logic [1:0] i_clkout2_div,
    input  wire logic       i_read_enable_select,
    // Access request from the port engine
    input  wire logic       i_acc_req,
    input  wire logic [1:0] i_acc_space,
    input  wire logic [1:0] i_acc_mem_type,
    input  wire logic       i_acc_write,
    input  wire logic       i_acc_addr_lsb,
    input  wire logic       i_acc_wide,
    input  wire logic       i_acc_pdt,
    output logic            o_acc_done,
    output logic [1:0]      o_clock_source,
    // Clock pins
    output logic            o_port_clock_out_full,
    output logic            o_port_clock_out_divided,
    // Memory control pins
    output logic [3:0]      o_chip_enable_n,
    output logic            o_byte_enable_high_n,
    output logic            o_byte_enable_low_n,
    output logic            o_read_col_strobe_n,
    output logic            o_oe_row_strobe_n,
    output logic            o_peripheral_direct_transfer_n,
    output logic            o_port_oe_n,
    // Arbitration pins
    output logic            o_host_hold_acknowledge_n,
    output logic            o_port_bus_request
);

    // Synchronisers for pins from outside the clock domain.
    logic       ext_s1_q, ext_s2_q, ext_s3_q;
    logic [1:0] strap_s1_q, strap_s2_q;
    logic       hold_s1_q, hold_s2_q;

    // Clock source selection and port clock generation.
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic       strap_done_q, strap_done_d;
    logic [1:0] src_q, src_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] div_cnt_q, div_cnt_d;
    logic       full_q, full_d, divided_q, divided_d;
    logic       port_level, port_tick;

    always_comb
    begin
        strap_cnt_d  = strap_cnt_q;
        strap_done_d = strap_done_q;
        src_d        = src_q;
        // The synchroniser needs two edges to hold real strap levels, so wait for them.
        if (!strap_done_q)
        begin
            if (strap_cnt_q == port_pins_pkg::STRAP_WAIT)
            begin
                strap_done_d = 1'b1;
                if (strap_s2_q == port_pins_pkg::STRAP_DIV4 ||
                    strap_s2_q == port_pins_pkg::STRAP_DIV6)
                    src_d = strap_s2_q;                                     // [RULE3]
                else
                    src_d = port_pins_pkg::STRAP_EXT;                       // [RULE4]
            end
            else
                strap_cnt_d = strap_cnt_q + 2'h1;
        end
        port_level = 1'b0;
        port_tick  = 1'b0;
        cnt_d      = port_pins_pkg::CNT_RESET;
        case (src_q)
            port_pins_pkg::STRAP_DIV4:
            begin
                port_level = (cnt_q < port_pins_pkg::DIV4_HALF);            // [RULE3]
                port_tick  = (cnt_q == port_pins_pkg::DIV4_LAST);
                cnt_d      = port_tick ? port_pins_pkg::CNT_RESET : cnt_q + 3'h1;
            end
            port_pins_pkg::STRAP_DIV6:
            begin
                port_level = (cnt_q < port_pins_pkg::DIV6_HALF);            // [RULE3]
                port_tick  = (cnt_q >= port_pins_pkg::DIV6_LAST);
                cnt_d      = port_tick ? port_pins_pkg::CNT_RESET : cnt_q + 3'h1;
            end
            default:
            begin
                port_level = ext_s2_q;
                port_tick  = ext_s2_q & ~ext_s3_q;
            end
        endcase
        div_cnt_d = port_tick ? div_cnt_q + 2'h1 : div_cnt_q;
        full_d    = port_level;                                             // [RULE6]
        case (i_clkout2_div)
            port_pins_pkg::OUTDIV_2: divided_d = div_cnt_q[0];              // [RULE5]
            port_pins_pkg::OUTDIV_4: divided_d = div_cnt_q[1];              // [RULE5]
            default:                 divided_d = port_level;                // [RULE5]
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            strap_cnt_q  <= 2'h0;
            strap_done_q <= 1'b0;
            src_q        <= port_pins_pkg::STRAP_EXT;
            cnt_q        <= port_pins_pkg::CNT_RESET;
            div_cnt_q    <= 2'h0;
            full_q       <= 1'b0;
            divided_q    <= 1'b0;
            ext_s1_q     <= 1'b0;
            ext_s2_q     <= 1'b0;
            ext_s3_q     <= 1'b0;
            strap_s1_q   <= 2'h0;
            strap_s2_q   <= 2'h0;
            hold_s1_q    <= 1'b1;
            hold_s2_q    <= 1'b1;
        end
        else
        begin
            strap_cnt_q  <= strap_cnt_d;
            strap_done_q <= strap_done_d;
            src_q        <= src_d;
            cnt_q        <= cnt_d;
            div_cnt_q    <= div_cnt_d;
            full_q       <= full_d;
            divided_q    <= divided_d;
            ext_s1_q     <= i_port_ext_clock_in;
            ext_s2_q     <= ext_s1_q;
            ext_s3_q     <= ext_s2_q;
            strap_s1_q   <= i_clock_source_straps;
            strap_s2_q   <= strap_s1_q;
            hold_s1_q    <= i_host_hold_request_n;
            hold_s2_q    <= hold_s1_q;
        end
    end

    assign o_port_clock_out_full    = full_q;
    assign o_port_clock_out_divided = divided_q;
    assign o_clock_source           = src_q;

    // Access sequencer and pin drivers. Access steps advance on port clock ticks, hold steps on CPU clock edges.
    port_pins_pkg::port_state_e state_q, state_d;
    logic [1:0] sp_q, sp_d, ty_q, ty_d;
    logic       wr_q, wr_d, lsb_q, lsb_d, wide_q, wide_d, pdt_q, pdt_d, res_q, res_d;
    logic       done_d, done_q, breq_d, breq_q, ack_d, ack_n_q, oe_d, oe_n_q;
    logic [3:0] ce_d, ce_n_q;
    logic       beh_d, bel_d, beh_n_q, bel_n_q, sa_d, sa_n_q, sb_d, sb_n_q, pd_d, pd_n_q;
    logic       hold_req, active;

    always_comb
    begin
        hold_req = ~hold_s2_q;
        state_d  = state_q;
        sp_d     = sp_q;
        ty_d     = ty_q;
        wr_d     = wr_q;
        lsb_d    = lsb_q;
        wide_d   = wide_q;
        pdt_d    = pdt_q;
        res_d    = res_q;
        done_d   = 1'b0;
        case (state_q)
            port_pins_pkg::ST_IDLE:
                // A host hold wins over a new access, but never cuts one short.
                if (hold_req)
                    state_d = port_pins_pkg::ST_FLOAT;                     // [RULE13]
                else if (i_acc_req && port_tick)
                begin
                    state_d = port_pins_pkg::ST_SETUP;
                    sp_d    = i_acc_space;
                    ty_d    = i_acc_mem_type;
                    wr_d    = i_acc_write;
                    lsb_d   = i_acc_addr_lsb;
                    wide_d  = i_acc_wide;
                    pdt_d   = i_acc_pdt;
                    res_d   = i_read_enable_select;
                end
            port_pins_pkg::ST_SETUP:
                if (port_tick)
                    state_d = port_pins_pkg::ST_STROBE;
            port_pins_pkg::ST_STROBE:
                if (port_tick)
                begin
                    state_d = port_pins_pkg::ST_IDLE;
                    done_d  = 1'b1;
                end
            port_pins_pkg::ST_FLOAT:
                state_d = port_pins_pkg::ST_GRANT;                         // [RULE13]
            port_pins_pkg::ST_GRANT:
                if (!hold_req)
                    state_d = port_pins_pkg::ST_IDLE;                      // [RULE13]
            default:
                state_d = port_pins_pkg::ST_IDLE;
        endcase

        active = (state_d == port_pins_pkg::ST_SETUP) || (state_d == port_pins_pkg::ST_STROBE);
        ack_d  = (state_d == port_pins_pkg::ST_GRANT);                     // [RULE11]
        oe_d   = (state_d == port_pins_pkg::ST_FLOAT) || ack_d;
        breq_d = ack_d && i_acc_req;                                       // [RULE11]
        ce_d   = 4'h0;
        if (active)
            ce_d[sp_d] = 1'b1;                                             // [RULE12]
        beh_d  = active && (wide_d || lsb_d);                              // [RULE1] [RULE2]
        bel_d  = active && (wide_d || !lsb_d);                             // [RULE1] [RULE2]
        pd_d   = active && pdt_d;                                          // [RULE10]
        sa_d   = 1'b0;
        sb_d   = 1'b0;
        case (ty_d)
            port_pins_pkg::MEM_SDRAM:
            begin
                sa_d = (state_d == port_pins_pkg::ST_STROBE);              // [RULE7]
                sb_d = (state_d == port_pins_pkg::ST_SETUP);               // [RULE9]
            end
            port_pins_pkg::MEM_SYNC:
            begin
                if (!res_d)
                    sa_d = (state_d == port_pins_pkg::ST_SETUP);           // [RULE8]
                else
                    sa_d = (state_d == port_pins_pkg::ST_STROBE) && !wr_d; // [RULE8]
                sb_d = (state_d == port_pins_pkg::ST_STROBE) && !wr_d;     // [RULE9]
            end
            default:
            begin
                sa_d = (state_d == port_pins_pkg::ST_STROBE) && !wr_d;     // [RULE7]
                sb_d = active && !wr_d;                                    // [RULE9]
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= port_pins_pkg::ST_IDLE;
            sp_q    <= 2'h0;
            ty_q    <= port_pins_pkg::MEM_ASYNC;
            wr_q    <= 1'b0;
            lsb_q   <= 1'b0;
            wide_q  <= 1'b0;
            pdt_q   <= 1'b0;
            res_q   <= 1'b0;
            done_q  <= 1'b0;
            breq_q  <= 1'b0;
            ack_n_q <= 1'b1;
            oe_n_q  <= 1'b0;
            ce_n_q  <= 4'hf;
            beh_n_q <= 1'b1;
            bel_n_q <= 1'b1;
            sa_n_q  <= 1'b1;
            sb_n_q  <= 1'b1;
            pd_n_q  <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            sp_q    <= sp_d;
            ty_q    <= ty_d;
            wr_q    <= wr_d;
            lsb_q   <= lsb_d;
            wide_q  <= wide_d;
            pdt_q   <= pdt_d;
            res_q   <= res_d;
            done_q  <= done_d;
            breq_q  <= breq_d;
            ack_n_q <= ~ack_d;
            oe_n_q  <= oe_d;
            ce_n_q  <= ~ce_d;
            beh_n_q <= ~beh_d;
            bel_n_q <= ~bel_d;
            sa_n_q  <= ~sa_d;
            sb_n_q  <= ~sb_d;
            pd_n_q  <= ~pd_d;
        end
    end

    assign o_acc_done                     = done_q;
    assign o_port_bus_request             = breq_q;
    assign o_host_hold_acknowledge_n      = ack_n_q;
    assign o_port_oe_n                    = oe_n_q;
    assign o_chip_enable_n                = ce_n_q;
    assign o_byte_enable_high_n           = beh_n_q;
    assign o_byte_enable_low_n            = bel_n_q;
    assign o_read_col_strobe_n            = sa_n_q;
    assign o_oe_row_strobe_n              = sb_n_q;
    assign o_peripheral_direct_transfer_n = pd_n_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    chk_one_chip_enable: assert property ($countones(~o_chip_enable_n) <= 1) // [RULE12]
        else $error("more than one chip enable asserted");
    chk_narrow_byte_enable: assert property ( // [RULE1]
        (state_q == port_pins_pkg::ST_SETUP && !wide_q)
        |-> (o_byte_enable_high_n == !lsb_q) && (o_byte_enable_low_n == lsb_q))
        else $error("byte enable does not match address bit");
    chk_sdram_wide_mask: assert property ( // [RULE2]
        (state_q == port_pins_pkg::ST_STROBE && ty_q == port_pins_pkg::MEM_SDRAM && wide_q)
        |-> !o_byte_enable_high_n && !o_byte_enable_low_n)
        else $error("wide sdram access masks a byte");
    // The first rise after the source switch may still come from the pin, so it is skipped.
    chk_div4_period: assert property ( // [RULE3]
        ($past(strap_done_q) && src_q == port_pins_pkg::STRAP_DIV4 && $rose(o_port_clock_out_full))
        |-> ##4 $rose(o_port_clock_out_full))
        else $error("cpu/4 port clock period wrong");
    chk_div6_period: assert property ( // [RULE3]
        ($past(strap_done_q) && src_q == port_pins_pkg::STRAP_DIV6 && $rose(o_port_clock_out_full))
        |-> ##6 $rose(o_port_clock_out_full))
        else $error("cpu/6 port clock period wrong");
    chk_default_source: assert property ( // [RULE4]
        ($rose(strap_done_q) && $past(strap_s2_q) == 2'h3) |-> src_q == port_pins_pkg::STRAP_EXT)
        else $error("unstrapped source is not the clock pin");
    chk_full_follows_pin: assert property ( // [RULE6]
        (src_q == port_pins_pkg::STRAP_EXT && $past(src_q) == port_pins_pkg::STRAP_EXT)
        |-> o_port_clock_out_full == $past(ext_s2_q))
        else $error("full clock does not follow the pin");
    chk_sync_addr_strobe: assert property ( // [RULE8]
        (state_q == port_pins_pkg::ST_SETUP && ty_q == port_pins_pkg::MEM_SYNC && !res_q)
        |-> !o_read_col_strobe_n)
        else $error("sync address strobe missing");
    chk_sdram_row_strobe: assert property ( // [RULE9]
        (state_q == port_pins_pkg::ST_SETUP && ty_q == port_pins_pkg::MEM_SDRAM)
        |-> !o_oe_row_strobe_n && o_read_col_strobe_n)
        else $error("sdram row strobe wrong in setup");
    chk_ack_after_float: assert property ($fell(o_host_hold_acknowledge_n) // [RULE13]
        |-> o_port_oe_n && $past(o_port_oe_n) && o_chip_enable_n == 4'hf)
        else $error("acknowledge before pins floated");
    chk_ack_held: assert property ((!o_host_hold_acknowledge_n && hold_req) // [RULE13]
        |=> !o_host_hold_acknowledge_n)
        else $error("acknowledge dropped while hold requested");
    chk_bus_request: assert property ( // [RULE11]
        (state_q == port_pins_pkg::ST_GRANT && hold_req && i_acc_req) |=> o_port_bus_request)
        else $error("bus request not raised while held");

    cov_hold_grant: cover property ($fell(o_host_hold_acknowledge_n));
    cov_sdram_done: cover property (ty_q == port_pins_pkg::MEM_SDRAM && o_acc_done);
    cov_div6_source: cover property (strap_done_q && src_q == port_pins_pkg::STRAP_DIV6);
    cov_request_held: cover property (o_port_bus_request);

endmodule : narrow_mem_port_pins

/* tb/port_far_side.sv */
// Far side of the port: board strap pulls, external port clock source and a bus-sharing host.
`timescale 1ns/100ps
module port_far_side
(
    // Clock and bench controls
    input  wire logic       i_clk,
    input  wire logic       i_ext_run,
    input  wire logic       i_want_hold,
    input  wire logic [1:0] i_strap_pulls,
    // Port pins
    output logic            o_port_ext_clock_in,
    output logic [1:0]      o_clock_source_straps,
    output logic            o_host_hold_request_n
);
    // The board resistors hold the straps at a fixed level through reset.
    assign o_clock_source_straps = i_strap_pulls;

    initial
    begin
        o_port_ext_clock_in = 1'b0;
        o_host_hold_request_n = 1'b1;
    end

    // The oscillator is unrelated in phase to the CPU clock: 20 ns period, kept off the
    // whole nanosecond so that no pin edge lands on a CPU clock edge.
    initial
    begin
        #0.5;
        forever #10 o_port_ext_clock_in = i_ext_run ? ~o_port_ext_clock_in : 1'b0;
    end

    // The host changes its request just after a CPU edge and holds it as a level.
    always @(posedge i_clk) o_host_hold_request_n <= #1 ~i_want_hold;
endmodule : port_far_side

/* tb/narrow_mem_port_pins_bench.sv */
// Self-checking bench of the memory port pin logic.
`timescale 1ns/100ps
module narrow_mem_port_pins_bench;
    logic       clk, nrst, ext_run, want_hold, sel, req, wr, lsb, wide, pdt;
    logic [1:0] pulls, div, space, mtype, straps, clock_source;
    logic [3:0] ce_n;
    logic       ext_clk, hold_n, acc_done, clk_full, clk_div, beh_n, bel_n, rcs_n, ors_n;
    logic       pdt_n, port_oe_n, ack_n, bus_req;
    int         errors = 0;
    int         checks = 0;

    always #2 clk = ~clk;

    port_far_side far (.i_clk(clk), .i_ext_run(ext_run), .i_want_hold(want_hold),
        .i_strap_pulls(pulls), .o_port_ext_clock_in(ext_clk),
        .o_clock_source_straps(straps), .o_host_hold_request_n(hold_n));

    narrow_mem_port_pins dut (.i_clk(clk), .i_nrst(nrst), .i_port_ext_clock_in(ext_clk),
        .i_clock_source_straps(straps), .i_host_hold_request_n(hold_n),
        .i_clkout2_div(div), .i_read_enable_select(sel), .i_acc_req(req),
        .i_acc_space(space), .i_acc_mem_type(mtype), .i_acc_write(wr),
        .i_acc_addr_lsb(lsb), .i_acc_wide(wide), .i_acc_pdt(pdt), .o_acc_done(acc_done),
        .o_clock_source(clock_source), .o_port_clock_out_full(clk_full),
        .o_port_clock_out_divided(clk_div), .o_chip_enable_n(ce_n),
        .o_byte_enable_high_n(beh_n), .o_byte_enable_low_n(bel_n),
        .o_read_col_strobe_n(rcs_n), .o_oe_row_strobe_n(ors_n),
        .o_peripheral_direct_transfer_n(pdt_n), .o_port_oe_n(port_oe_n),
        .o_host_hold_acknowledge_n(ack_n), .o_port_bus_request(bus_req));

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Straps are caught a few edges after release, so the reset ends with some spare cycles.
    task automatic do_reset(input logic [1:0] p);
        nrst = 1'b0;
        pulls = p;
        tick(6);
        nrst = 1'b1;
        tick(4);
    endtask : do_reset

    // Cycles from one rising edge of a port clock pin to the next.
    task automatic measure(input logic pick, output int n);
        int k;
        for (k = 0; k < 60 && (pick ? clk_div : clk_full) !== 1'b0; k++) tick(1);
        for (k = 0; k < 60 && (pick ? clk_div : clk_full) !== 1'b1; k++) tick(1);
        n = 0;
        for (k = 0; k < 60 && (pick ? clk_div : clk_full) !== 1'b0; k++)
        begin
            tick(1);
            n++;
        end
        for (k = 0; k < 60 && (pick ? clk_div : clk_full) !== 1'b1; k++)
        begin
            tick(1);
            n++;
        end
    endtask : measure

    task automatic strap_sources;
        logic [1:0] exp;
        int         n;
        for (int c = 0; c < 4; c++)
        begin
            do_reset(c[1:0]);
            exp = (c == 1) ? port_pins_pkg::STRAP_DIV4 :
                  (c == 2) ? port_pins_pkg::STRAP_DIV6 : port_pins_pkg::STRAP_EXT;
            check("clock source", {6'h00, exp}, {6'h00, clock_source});
        end
        do_reset(2'h0);
        measure(1'b0, n);
        check("pin clock toggles", 8'h01, 8'(n > 2 && n < 12));
        ext_run = 1'b0;
        tick(12);
        check("stopped pin clock", 8'h00, {7'h00, clk_full});
        ext_run = 1'b1;
    endtask : strap_sources

    task automatic clocks;
        int n;
        do_reset(2'h1);
        measure(1'b0, n);
        check("full period cpu4", 8'h04, 8'(n));
        for (int d = 0; d < 3; d++)
        begin
            div = d[1:0];
            tick(20);
            measure(1'b1, n);
            check("divided period", 8'(4 << d), 8'(n));
        end
        do_reset(2'h2);
        measure(1'b0, n);
        check("full period cpu6", 8'h06, 8'(n));
        measure(1'b1, n);
        check("divided period cpu6", 8'h18, 8'(n));
        div = 2'h0;
    endtask : clocks

    // One access: checks pins in the middle of the setup and strobe periods, then the end.
    task automatic access(input logic [1:0] sp, input logic [1:0] mt, input logic w,
                          input logic lo, input logic wd, input logic pd, input logic rs);
        logic [1:0] be, su, sb;
        int         k;
        be = wd ? 2'b00 : (lo ? 2'b01 : 2'b10);
        case (mt)
            port_pins_pkg::MEM_SDRAM:
            begin
                su = 2'b10;
                sb = 2'b01;
            end
            port_pins_pkg::MEM_SYNC:
            begin
                su = {rs, 1'b1};
                sb = {~(rs & ~w), w};
            end
            default:
            begin
                su = {1'b1, w};
                sb = {w, w};
            end
        endcase
        {space, mtype, wr, lsb, wide, pdt, sel} = {sp, mt, w, lo, wd, pd, rs};
        req = 1'b1;
        for (k = 0; k < 20 && ce_n === 4'hf; k++) tick(1);
        tick(1);
        check("chip enables", {4'h0, ~(4'h1 << sp)}, {4'h0, ce_n});
        check("byte enables", {6'h00, be}, {6'h00, beh_n, bel_n});
        check("setup strobes", {6'h00, su}, {6'h00, rcs_n, ors_n});
        check("pdt pin", {7'h00, ~pd}, {7'h00, pdt_n});
        tick(4);
        check("strobe strobes", {6'h00, sb}, {6'h00, rcs_n, ors_n});
        check("strobe enables", {4'h0, ~(4'h1 << sp)}, {4'h0, ce_n});
        for (k = 0; k < 12 && acc_done !== 1'b1; k++) tick(1);
        req = 1'b0;
        check("done", 8'h01, {7'h00, acc_done});
        tick(1);
        check("pins idle", 8'h3f, {2'h0, ce_n, rcs_n, ors_n});
    endtask : access

    task automatic accesses;
        do_reset(2'h1);
        for (int t = 0; t < 4; t++)
            for (int w = 0; w < 2; w++)
                for (int s = 0; s < 4; s++)
                    access(s[1:0], (t == 3) ? 2'h2 : t[1:0], w[0], s[0], s[1] & ~w[0],
                           s[0] ^ w[0], t == 3);
        access(2'h3, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask : accesses

    task automatic hold_idle;
        int k, c_oe, c_ack;
        c_oe = -1;
        c_ack = -1;
        want_hold = 1'b1;
        for (k = 0; k < 12; k++)
        begin
            tick(1);
            if (c_oe < 0 && port_oe_n === 1'b1) c_oe = k;
            if (c_ack < 0 && ack_n === 1'b0) c_ack = k;
        end
        check("ack after float", 8'h01, 8'(c_ack - c_oe));
        {space, mtype, wr, lsb, wide, pdt} = {2'h1, port_pins_pkg::MEM_ASYNC, 4'h9};
        req = 1'b1;
        tick(6);
        check("bus request", 8'h01, {7'h00, bus_req});
        check("enables while held", 8'h1e, {3'h0, ce_n, ack_n});
        want_hold = 1'b0;
        for (k = 0; k < 12 && ack_n !== 1'b1; k++) tick(1);
        check("pins driven on release", 8'h00, {7'h00, port_oe_n});
        for (k = 0; k < 30 && acc_done !== 1'b1; k++) tick(1);
        req = 1'b0;
        check("waiting access done", 8'h01, {7'h00, acc_done});
        check("bus request dropped", 8'h00, {7'h00, bus_req});
    endtask : hold_idle

    task automatic hold_mid_access;
        int k, early;
        early = 0;
        {space, mtype, wr, lsb, wide, pdt} = {2'h0, port_pins_pkg::MEM_ASYNC, 4'h1};
        req = 1'b1;
        for (k = 0; k < 20 && ce_n === 4'hf; k++) tick(1);
        want_hold = 1'b1;
        for (k = 0; k < 20 && acc_done !== 1'b1; k++)
        begin
            tick(1);
            if (ack_n !== 1'b1 || port_oe_n !== 1'b0) early++;
        end
        req = 1'b0;
        check("no grant inside access", 8'h00, 8'(early));
        for (k = 0; k < 12 && ack_n !== 1'b0; k++) tick(1);
        check("grant after access", 8'h02, {6'h00, port_oe_n, ack_n});
        want_hold = 1'b0;
        tick(8);
        check("released", 8'h01, {6'h00, port_oe_n, ack_n});
    endtask : hold_mid_access

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        ext_run = 1'b1;
        want_hold = 1'b0;
        pulls = 2'h0;
        div = 2'h0;
        {sel, req, wr, lsb, wide, pdt, space, mtype} = 10'h000;
        strap_sources();
        clocks();
        accesses();
        hold_idle();
        hold_mid_access();
        end_of_test();
    end
endmodule : narrow_mem_port_pins_bench
